// *** logic/wdt_map.svh ***
// Purpose: Register map, field positions, reset values and counts of the watchdog
// Assumes: Byte-wide registers placed on a 32-bit address port
// Notes: Included by the package and by the verification files
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define WDT_ADDR_MODE 32'hFFFFF6D0
`define WDT_ADDR_KEY 32'hFFFFF6D4
`define WDT_ADDR_STAT 32'hFFFFF6D8

// ----------------------------------------
// Reset and key values
// ----------------------------------------
`define WDT_MODE_RST 7'h67
`define WDT_KEY_READ 8'h9A
`define WDT_KEY_OK 8'hAC
`define WDT_STOP_CODE 5'h1F

// ----------------------------------------
// Mode register fields
// ----------------------------------------
`define WDT_MODE_HI 6
`define WDT_MODE_LO 5
`define WDT_CODE_HI 4
`define WDT_CODE_LO 0
`define WDT_CODE_FXX_BIT 3

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define WDT_STAT_WRITTEN 0
`define WDT_STAT_RUNNING 1
`define WDT_STAT_LOCK 2
`define WDT_STAT_NMI_MODE 3

// ----------------------------------------
// Counting
// ----------------------------------------
`define WDT_OSC_BASE_POW 5'd12
`define WDT_FXX_BASE_POW 5'd16
`define WDT_CNT_W 23
`define WDT_SYNC_STAGES 2

`endif

// *** logic/wdt_pkg.sv ***
// Purpose: Types shared by the watchdog modules
// Assumes: Constants come from wdt_map.svh
// Notes: State structs hold every flip-flop of each module
`include "wdt_map.svh"

package wdt_pkg;

    typedef enum logic [1:0] {
        MODE_STOP,
        MODE_NMI,
        MODE_RESET
    } wdt_mode_t;

    typedef struct packed {
        logic sync_a;
        logic sync_b;
        logic prev;
    } tick_state_t;

    typedef struct packed {
        logic [6:0] mode;
        logic written;
        logic [`WDT_CNT_W-1:0] cnt;
        logic [7:0] rdata;
        logic rst_pulse;
        logic nmi_pulse;
        logic lock_a;
        logic lock_b;
    } wdt_state_t;

endpackage

// *** logic/tick_if.sv ***
// Purpose: Carries the count enable and source choice between watchdog modules
// Assumes: Both ends on clk
// Notes: One-cycle enable per source period
`timescale 1ns/10ps

interface tick_if;
    logic use_osc;
    logic src_en;

    modport gen (
        input use_osc,
        output src_en
    );

    modport use_end (
        output use_osc,
        input src_en
    );
endinterface

// *** logic/osc_tick.sv ***
// Purpose: Turns the selected count source into a one-cycle enable on clk
// Assumes: internal_osc_clk is far slower than clk
// Notes: Main clock source enables every cycle
`timescale 1ns/10ps

module osc_tick
    import wdt_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Internal oscillator pin
    input wire logic internal_osc_clk,
    // Enable toward the counter
    tick_if.gen tk
);

    tick_state_t st_ff;
    tick_state_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.sync_a = internal_osc_clk;
        nxt_st.sync_b = st_ff.sync_a;
        nxt_st.prev = st_ff.sync_b;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Rising edge seen only after both sync stages
    assign tk.src_en = tk.use_osc ? (st_ff.sync_b & ~st_ff.prev) : 1'b1;

endmodule

// *** logic/write_once_watchdog_timer.sv ***
// Purpose: Default-running watchdog with write-once mode and keyed restart
// Assumes: clk is the main clock fxx at 10 MHz; byte registers on a plain port
// Notes: Overflow requests are one-cycle pulses from flip-flops
//
// Notes on behaviour
// (R1) Counts in reset mode right after reset
// (R2) Mode register: byte access, one write only
// (R3) Mode register resets to 67H
// (R4) Mode field: stop, NMI, or reset
// (R5) Codes 0-7: oscillator over 2^12..2^19
// (R6) Codes 8-15: main clock over 2^16..2^23
// (R7) Writing 1FH stops the watchdog
// (R8) Lock bit forces reset mode
// (R9) Lock bit: nothing but reset stops it
// (R10) Lock bit: oscillator source, eight intervals only
// (R11) Second mode write forces overflow, clears counter
// (R12) Key ACH clears counter, restarts count
// (R13) Other key value forces overflow
// (R14) Bit access to key forces overflow
// (R15) Key register always reads 9AH; bit reads here give 00H
// (R16) Key register takes byte reads, writes
// (R17) Software avoids mode access on slow clocks
// (R18) Software writes mode register once anyway
// (R19) Interval elapsed unkept raises reset or NMI
// (R20) Mode bit 7 reads zero, ignores writes
// (R21) Overflow gives one-cycle pulse on output
`timescale 1ns/10ps

module write_once_watchdog_timer
    import wdt_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Register port
    input wire logic [31:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic bit_op,
    output logic [7:0] rdata,
    // Count source and option pin
    input wire logic internal_osc_clk,
    input wire logic option_lock_bit,
    // Overflow requests
    output logic overflow_reset_req,
    output logic overflow_nmi_req
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [`WDT_CNT_W-1:0] limit_of(input logic [4:0] pow);
        logic [`WDT_CNT_W:0] full;
        full = ({{`WDT_CNT_W{1'b0}}, 1'b1} << pow) - {{`WDT_CNT_W{1'b0}}, 1'b1};
        return full[`WDT_CNT_W-1:0];
    endfunction

    function automatic logic hit(input logic [31:0] a, input logic [31:0] target);
        return a == target;
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    wdt_state_t st_ff;
    wdt_state_t nxt_st;

    tick_if tk ();

    osc_tick u_tick (
        .clk(clk),
        .nrst(nrst),
        .internal_osc_clk(internal_osc_clk),
        .tk(tk)
    );

    // ----------------------------------------
    // Decoded configuration
    // ----------------------------------------
    logic locked;
    logic [4:0] code;
    logic [1:0] mode_field;
    wdt_mode_t eff_mode;
    logic use_osc;
    logic [4:0] pow;
    logic [`WDT_CNT_W-1:0] limit;
    logic running;

    always_comb begin
        locked = st_ff.lock_b;
        code = st_ff.mode[`WDT_CODE_HI:`WDT_CODE_LO];
        mode_field = st_ff.mode[`WDT_MODE_HI:`WDT_MODE_LO];
        if (locked) begin
            eff_mode = MODE_RESET;  // [R8] [R9]
        end else if (code == `WDT_STOP_CODE) begin
            eff_mode = MODE_STOP;  // [R7]
        end else begin
            case (mode_field)  // [R4]
                2'b00: eff_mode = MODE_STOP;
                2'b01: eff_mode = MODE_NMI;
                default: eff_mode = MODE_RESET;
            endcase
        end
        // Lock ignores the source bit, keeping 2^12..2^19 only
        use_osc = locked | ~code[`WDT_CODE_FXX_BIT];  // [R10]
        if (use_osc) begin
            pow = `WDT_OSC_BASE_POW + {2'b00, code[2:0]};  // [R5]
        end else begin
            pow = `WDT_FXX_BASE_POW + {2'b00, code[2:0]};  // [R6]
        end
        limit = limit_of(pow);
        running = eff_mode != MODE_STOP;
    end

    assign tk.use_osc = use_osc;

    // ----------------------------------------
    // Access decode
    // ----------------------------------------
    logic wr_mode;
    logic wr_key;
    logic rd_mode;
    logic rd_key;
    logic rd_stat;

    always_comb begin
        // Mode register is byte only; bit accesses do nothing
        wr_mode = wr & ~bit_op & hit(addr, `WDT_ADDR_MODE);  // [R2]
        rd_mode = rd & ~bit_op & hit(addr, `WDT_ADDR_MODE);  // [R2]
        wr_key = wr & hit(addr, `WDT_ADDR_KEY);  // [R16]
        rd_key = rd & hit(addr, `WDT_ADDR_KEY);  // [R16]
        rd_stat = rd & hit(addr, `WDT_ADDR_STAT);
    end

    // ----------------------------------------
    // Overflow causes
    // ----------------------------------------
    logic force_mode;
    logic force_key;
    logic restart;
    logic natural;
    logic overflow;

    always_comb begin
        force_mode = wr_mode & st_ff.written;  // [R11]
        // Any bit access to the key register trips, read or write
        force_key = (wr_key & (bit_op | (wdata != `WDT_KEY_OK)))  // [R13]
            | (rd_key & bit_op);  // [R14]
        restart = wr_key & ~bit_op & (wdata == `WDT_KEY_OK);  // [R12]
        natural = running & tk.src_en & (st_ff.cnt == limit);  // [R19]
        overflow = force_mode | force_key | natural;
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.lock_a = option_lock_bit;
        nxt_st.lock_b = st_ff.lock_a;

        if (wr_mode && !st_ff.written) begin
            nxt_st.mode = wdata[6:0];  // [R2] [R20]
            nxt_st.written = 1'b1;
        end

        if (overflow || restart || !running) begin
            nxt_st.cnt = '0;  // [R11] [R12]
        end else if (tk.src_en) begin
            nxt_st.cnt = st_ff.cnt + {{(`WDT_CNT_W-1){1'b0}}, 1'b1};  // [R1]
        end

        // Forced overflow while stopped still resets the part
        nxt_st.nmi_pulse = overflow & (eff_mode == MODE_NMI);  // [R21]
        nxt_st.rst_pulse = overflow & (eff_mode != MODE_NMI);  // [R21]

        nxt_st.rdata = 8'h00;
        if (rd_mode) begin
            nxt_st.rdata = {1'b0, st_ff.mode};  // [R20]
        end else if (rd_key && !bit_op) begin
            nxt_st.rdata = `WDT_KEY_READ;  // [R15]
        end else if (rd_stat) begin
            nxt_st.rdata[`WDT_STAT_WRITTEN] = st_ff.written;
            nxt_st.rdata[`WDT_STAT_RUNNING] = running;
            nxt_st.rdata[`WDT_STAT_LOCK] = locked;
            nxt_st.rdata[`WDT_STAT_NMI_MODE] = eff_mode == MODE_NMI;
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_ff <= '0;
            st_ff.mode <= `WDT_MODE_RST;  // [R1] [R3]
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Read data is held for exactly the cycle after the strobe
    assign rdata = st_ff.rdata;
    assign overflow_reset_req = st_ff.rst_pulse;
    assign overflow_nmi_req = st_ff.nmi_pulse;

endmodule

// *** verif/wdt_checker.sv ***
// Purpose: Port-level checks of the watchdog
// Assumes: Ports of write_once_watchdog_timer
// Notes: Bound from the bench top file
`timescale 1ns/10ps
`include "wdt_map.svh"

module wdt_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Register port
    input wire logic [31:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic bit_op,
    input wire logic [7:0] rdata,
    // Pins
    input wire logic internal_osc_clk,
    input wire logic option_lock_bit,
    input wire logic overflow_reset_req,
    input wire logic overflow_nmi_req
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    logic ovf;
    assign ovf = overflow_reset_req | overflow_nmi_req;
    // ----------------------------------------
    // Checks
    // ----------------------------------------
    // A back-to-back forcing access legally makes a second pulse
    a_rst_one: assert property (overflow_reset_req && !wr && !rd |=> !overflow_reset_req)
        else $error("reset request too long");
    a_nmi_one: assert property (overflow_nmi_req && !wr && !rd |=> !overflow_nmi_req)
        else $error("nmi request too long");
    a_one_output: assert property (!(overflow_reset_req && overflow_nmi_req))
        else $error("both requests at once");
    a_key_bad: assert property (wr && addr == `WDT_ADDR_KEY && wdata != 8'hAC |=> ovf)
        else $error("bad key without overflow");
    a_key_bit: assert property ((wr || rd) && bit_op && addr == `WDT_ADDR_KEY |=> ovf)
        else $error("bit access without overflow");
    a_key_read: assert property (rd && !bit_op && addr == `WDT_ADDR_KEY |=> rdata == 8'h9A)
        else $error("key read wrong");
    a_mode_b7: assert property (rd && addr == `WDT_ADDR_MODE |=> !rdata[7])
        else $error("mode bit 7 set");
    // Five cycles lets the two-flop lock sync settle
    a_lock_nmi: assert property (option_lock_bit [*5] |-> !overflow_nmi_req)
        else $error("nmi while locked");
    a_rdata_idle: assert property (!rd |=> rdata == 8'h00)
        else $error("read data outside read");
    a_reset_quiet: assert property (disable iff (1'b0) !nrst |=> !ovf && rdata == 8'h00)
        else $error("activity in reset");
endmodule

// *** verif/write_once_watchdog_timer_bench.sv ***
// Purpose: Self-checking bench of the watchdog
// Assumes: Oscillator pin toggles every clk, so intervals are short
// Notes: Mode register is write-once, so scenarios that write it reset between them
`timescale 1ns/10ps
`include "wdt_map.svh"

module write_once_watchdog_timer_bench;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic bit_op = 1'b0;
    logic osc = 1'b0;
    logic lock = 1'b0;
    logic [31:0] addr = 32'h0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic rreq;
    logic nreq;
    int err_total = 0;
    int n_checks = 0;
    write_once_watchdog_timer dut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .bit_op(bit_op), .rdata(rdata), .internal_osc_clk(osc), .option_lock_bit(lock),
        .overflow_reset_req(rreq), .overflow_nmi_req(nreq));
    initial begin
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        osc <= ~osc;
    end
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task end_sim();
        if (err_total == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task do_reset(input logic lk);
        @(posedge clk);
        lock <= lk;
        nrst <= 1'b0;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
    endtask
    task wr_reg(input logic [31:0] a, input logic [7:0] d, input logic b);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        bit_op <= b;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        bit_op <= 1'b0;
    endtask
    task rd_chk(input logic [31:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask
    // Pulse lands one cycle after the forcing write
    task flags(input logic [7:0] exp);
        #1 chk({6'h0, rreq, nreq}, exp);
    endtask
    // 4096 oscillator periods of 2 clk, plus sync latency
    task wait_ovf(input logic [7:0] exp);
        int n;
        logic [7:0] f;
        n = 0;
        f = 8'h00;
        while (n < 9000 && f == 8'h00) begin
            @(posedge clk);
            #1 f = {6'h0, rreq, nreq};
            n++;
        end
        chk(f, exp);
        if (exp != 8'h00) begin
            chk({7'h0, n > 8180 && n < 8210}, 8'h01);
        end
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_regs();
        rd_chk(`WDT_ADDR_MODE, 8'h67);
        rd_chk(`WDT_ADDR_KEY, 8'h9A);
        rd_chk(`WDT_ADDR_STAT, 8'h02);
        wr_reg(32'hFFFFF6DC, 8'h55, 1'b0);
        rd_chk(32'hFFFFF6DC, 8'h00);
        wr_reg(`WDT_ADDR_MODE, 8'h1F, 1'b1);
        rd_chk(`WDT_ADDR_MODE, 8'h67);
        rd_chk(`WDT_ADDR_STAT, 8'h02);
    endtask
    // Mode register is only touched while clk runs as the main clock
    task t_nmi();
        wr_reg(`WDT_ADDR_MODE, 8'h20, 1'b0);
        rd_chk(`WDT_ADDR_MODE, 8'h20);
        rd_chk(`WDT_ADDR_STAT, 8'h0B);
        wr_reg(`WDT_ADDR_KEY, 8'hAC, 1'b0);
        wait_ovf(8'h01);
        wr_reg(`WDT_ADDR_KEY, 8'h55, 1'b0);
        flags(8'h01);
        wr_reg(`WDT_ADDR_MODE, 8'h60, 1'b0);
        flags(8'h01);
        rd_chk(`WDT_ADDR_MODE, 8'h20);
        wr_reg(`WDT_ADDR_KEY, 8'hAC, 1'b1);
        flags(8'h01);
        wr_reg(`WDT_ADDR_KEY, 8'hAC, 1'b0);
        flags(8'h00);
        rd_chk(`WDT_ADDR_KEY, 8'h9A);
        wait_ovf(8'h01);
    endtask
    task t_rmode();
        wr_reg(`WDT_ADDR_MODE, 8'hC0, 1'b0);
        rd_chk(`WDT_ADDR_MODE, 8'h40);
        wr_reg(`WDT_ADDR_KEY, 8'hAC, 1'b0);
        wait_ovf(8'h02);
    endtask
    task t_stop();
        wr_reg(`WDT_ADDR_MODE, 8'h1F, 1'b0);
        rd_chk(`WDT_ADDR_STAT, 8'h01);
        wr_reg(`WDT_ADDR_KEY, 8'hAC, 1'b0);
        wait_ovf(8'h00);
    endtask
    task t_lock(input logic [7:0] m);
        wr_reg(`WDT_ADDR_MODE, m, 1'b0);
        rd_chk(`WDT_ADDR_STAT, 8'h07);
        wr_reg(`WDT_ADDR_KEY, 8'hAC, 1'b0);
        wait_ovf(8'h02);
    endtask
    initial begin
        do_reset(1'b0);
        t_regs();
        t_nmi();
        do_reset(1'b0);
        t_rmode();
        do_reset(1'b0);
        t_stop();
        do_reset(1'b1);
        t_lock(8'h28);
        do_reset(1'b1);
        t_lock(8'h08);
        end_sim();
    end
    initial begin
        #7000000;
        err_total++;
        end_sim();
    end
endmodule

bind write_once_watchdog_timer wdt_checker chk_i (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .bit_op(bit_op), .rdata(rdata), .internal_osc_clk(internal_osc_clk),
    .option_lock_bit(option_lock_bit), .overflow_reset_req(overflow_reset_req),
    .overflow_nmi_req(overflow_nmi_req));
